// >>> verilog/mpss_top.sv
// mpss_top: power and system-management signalling of the module edge
// assumes carrier pins are asynchronous; sleep requests come from firmware
`timescale 1ns/1ps
`default_nettype none
module mpss_top
#(
	parameter int PWRGOOD_SETTLE = mpss_pkg::PWRGOOD_SETTLE_CYC,
	parameter int CARRIER_RESET = mpss_pkg::CARRIER_RESET_CYC,
	parameter int SUSPEND_WARN = mpss_pkg::SUSPEND_WARN_CYC
)
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic power_button_n,
	input wire logic reset_button_n,
	input wire logic power_good,
	input wire logic main_supply_low,
	input wire logic pcie_wake_n,
	input wire logic general_wake_n,
	input wire logic battery_low_n,
	input wire logic mgmt_bus_alert_n,
	input wire logic over_temp_in_n,
	input wire logic sleep_button_n,
	input wire logic lid_switch_n,
	input wire logic watchdog_timeout,
	input wire logic watchdog_clear,
	input wire logic sw_reset_req,
	input wire logic sleep_enter_req,
	input wire logic [1:0] sleep_target,
	input wire logic cpu_thermal_shutdown,
	output logic carrier_reset_n,
	output logic suspend_imminent_n,
	output logic suspend_to_ram_n,
	output logic suspend_to_disk_n,
	output logic soft_off_n,
	output logic watchdog_expired,
	output logic thermal_trip_n,
	output logic system_mgmt_interrupt_n,
	output logic over_temp,
	output logic power_button_event,
	output logic sleep_button_event,
	output logic lid_event,
	output logic wake_event,
	output logic battery_low,
	output logic system_running
);
	typedef struct packed {
		mpss_pkg::mpss_state_type fsm;
		mpss_pkg::mpss_target_type target;
		logic [mpss_pkg::CNT_W-1:0] cnt;
		logic [mpss_pkg::CNT_W-1:0] rst_cnt;
		logic [4:0] meta;
		logic [4:0] stable;
		logic carrier_reset_n;
		logic suspend_imminent_n;
		logic suspend_to_ram_n;
		logic suspend_to_disk_n;
		logic soft_off_n;
		logic watchdog_expired;
		logic thermal_trip_n;
		logic smi_n;
		logic over_temp;
		logic power_button_n_ev;
		logic sleep_ev;
		logic lid_ev;
		logic wake_ev;
		logic battery_low;
		logic running;
	} mpss_top_state_type;

	mpss_top_state_type state;
	mpss_top_state_type next_state;
	mpss_sync_if sync ();
	logic [mpss_pkg::NUM_IN-1:0] pins;
	logic any_wake;

	// target encoding decoded in one place only, on leaving WARN
	function automatic mpss_pkg::mpss_state_type mpss_sleep_state(
		input mpss_pkg::mpss_target_type tgt);
		mpss_pkg::mpss_state_type s;
		s = mpss_pkg::MPSS_OFF;
		if (tgt == mpss_pkg::MPSS_TGT_S3)
			s = mpss_pkg::MPSS_S3;
		else if (tgt == mpss_pkg::MPSS_TGT_S4)
			s = mpss_pkg::MPSS_S4;
		return s;
	endfunction

	assign pins[mpss_pkg::IDX_POWER_BUTTON_N] = power_button_n;
	assign pins[mpss_pkg::IDX_RSTBTN] = reset_button_n;
	assign pins[mpss_pkg::IDX_PWRGOOD] = power_good;
	assign pins[mpss_pkg::IDX_WAKE_PCIE] = pcie_wake_n;
	assign pins[mpss_pkg::IDX_WAKE_GEN] = general_wake_n;
	assign pins[mpss_pkg::IDX_BATTERY_LOW_N] = battery_low_n;
	assign pins[mpss_pkg::IDX_ALERT] = mgmt_bus_alert_n;
	assign pins[mpss_pkg::IDX_OVERTEMP] = over_temp_in_n;
	assign pins[mpss_pkg::IDX_SLEEP] = sleep_button_n;
	assign pins[mpss_pkg::IDX_LID] = lid_switch_n;

	mpss_sync i_mpss_sync
	(
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.pins(pins),
		.sync(sync)
	);

	// wake sources: pcie, general, alert, sleep button
	assign any_wake = ~sync.level[mpss_pkg::IDX_WAKE_PCIE]
		| ~sync.level[mpss_pkg::IDX_WAKE_GEN]
		| ~sync.level[mpss_pkg::IDX_ALERT]
		| sync.fall[mpss_pkg::IDX_SLEEP];

	always_comb
	begin
		logic reset_cause;
		logic pg;
		reset_cause = 1'b0;
		pg = sync.level[mpss_pkg::IDX_PWRGOOD];
		next_state = state;
		// on-chip-clock pins: fault flags and firmware strobes
		next_state.meta = {main_supply_low, watchdog_timeout, watchdog_clear,
			sw_reset_req, cpu_thermal_shutdown};
		next_state.stable = state.meta;
		next_state.power_button_n_ev = sync.fall[mpss_pkg::IDX_POWER_BUTTON_N];
		next_state.sleep_ev = sync.fall[mpss_pkg::IDX_SLEEP];
		next_state.lid_ev = sync.fall[mpss_pkg::IDX_LID];
		next_state.wake_ev = any_wake && (state.fsm == mpss_pkg::MPSS_S3
			|| state.fsm == mpss_pkg::MPSS_S4);
		next_state.battery_low = ~sync.level[mpss_pkg::IDX_BATTERY_LOW_N];
		next_state.over_temp = ~sync.level[mpss_pkg::IDX_OVERTEMP];
		next_state.smi_n = sync.level[mpss_pkg::IDX_ALERT];
		next_state.thermal_trip_n = ~state.stable[0];
		// set wins over clear on the watchdog flag
		if (state.stable[3])
			next_state.watchdog_expired = 1'b1;
		else if (state.stable[2])
			next_state.watchdog_expired = 1'b0;

		// reset button is level sensitive so a held button keeps reset
		reset_cause = ~sync.level[mpss_pkg::IDX_RSTBTN] | ~pg | state.stable[4]
			| state.stable[3] | state.stable[1];
		if (reset_cause)
			next_state.rst_cnt = mpss_pkg::CNT_W'(CARRIER_RESET);
		else if (state.rst_cnt != '0)
			next_state.rst_cnt = state.rst_cnt - 1'b1;
		next_state.carrier_reset_n = !reset_cause && state.rst_cnt == '0
			&& state.fsm == mpss_pkg::MPSS_RUN;

		if (state.cnt != '0)
			next_state.cnt = state.cnt - 1'b1;

		unique case (state.fsm)
			mpss_pkg::MPSS_OFF:
			begin
				if (sync.fall[mpss_pkg::IDX_POWER_BUTTON_N] || any_wake)
				begin
					next_state.fsm = mpss_pkg::MPSS_START;
					next_state.cnt = mpss_pkg::CNT_W'(PWRGOOD_SETTLE);
				end
			end
			mpss_pkg::MPSS_START:
			begin
				// restart settle time every time power-good drops
				if (!pg)
					next_state.cnt = mpss_pkg::CNT_W'(PWRGOOD_SETTLE);
				else if (state.cnt == '0)
					next_state.fsm = mpss_pkg::MPSS_RUN;
			end
			mpss_pkg::MPSS_RUN:
			begin
				if (sync.fall[mpss_pkg::IDX_POWER_BUTTON_N] || !sync.level[mpss_pkg::IDX_BATTERY_LOW_N])
				begin
					next_state.fsm = mpss_pkg::MPSS_WARN;
					next_state.target = mpss_pkg::MPSS_TGT_S5;
					next_state.cnt = mpss_pkg::CNT_W'(SUSPEND_WARN);
				end
				else if (state.stable[0])
				begin
					next_state.fsm = mpss_pkg::MPSS_WARN;
					next_state.target = mpss_pkg::MPSS_TGT_S5;
					next_state.cnt = mpss_pkg::CNT_W'(SUSPEND_WARN);
				end
				else if (sleep_enter_req || sync.fall[mpss_pkg::IDX_SLEEP])
				begin
					next_state.fsm = mpss_pkg::MPSS_WARN;
					next_state.target = sleep_enter_req
						? mpss_pkg::mpss_target_type'(sleep_target) : mpss_pkg::MPSS_TGT_S3;
					next_state.cnt = mpss_pkg::CNT_W'(SUSPEND_WARN);
				end
			end
			mpss_pkg::MPSS_WARN:
			begin
				if (state.cnt == '0)
					next_state.fsm = mpss_sleep_state(state.target);
			end
			mpss_pkg::MPSS_S3, mpss_pkg::MPSS_S4:
			begin
				if (sync.fall[mpss_pkg::IDX_POWER_BUTTON_N] || any_wake)
				begin
					next_state.fsm = mpss_pkg::MPSS_START;
					next_state.cnt = mpss_pkg::CNT_W'(PWRGOOD_SETTLE);
				end
			end
			default:
			begin
				next_state.fsm = mpss_pkg::MPSS_OFF;
			end
		endcase

		next_state.suspend_imminent_n = next_state.fsm != mpss_pkg::MPSS_WARN;
		next_state.suspend_to_ram_n = next_state.fsm != mpss_pkg::MPSS_S3;
		next_state.suspend_to_disk_n = next_state.fsm != mpss_pkg::MPSS_S4;
		next_state.soft_off_n = next_state.fsm != mpss_pkg::MPSS_OFF;
		next_state.running = next_state.fsm == mpss_pkg::MPSS_RUN;

		if (!rst_n)
		begin
			next_state = '0;
			next_state.fsm = mpss_pkg::MPSS_OFF;
			next_state.target = mpss_pkg::MPSS_TGT_S5;
			next_state.suspend_imminent_n = 1'b1;
			next_state.suspend_to_ram_n = 1'b1;
			next_state.suspend_to_disk_n = 1'b1;
			next_state.thermal_trip_n = 1'b1;
			next_state.smi_n = 1'b1;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		state <= next_state;
	end

	assign carrier_reset_n = state.carrier_reset_n;
	assign suspend_imminent_n = state.suspend_imminent_n;
	assign suspend_to_ram_n = state.suspend_to_ram_n;
	assign suspend_to_disk_n = state.suspend_to_disk_n;
	assign soft_off_n = state.soft_off_n;
	assign watchdog_expired = state.watchdog_expired;
	assign thermal_trip_n = state.thermal_trip_n;
	assign system_mgmt_interrupt_n = state.smi_n;
	assign over_temp = state.over_temp;
	assign power_button_event = state.power_button_n_ev;
	assign sleep_button_event = state.sleep_ev;
	assign lid_event = state.lid_ev;
	assign wake_event = state.wake_ev;
	assign battery_low = state.battery_low;
	assign system_running = state.running;
endmodule
`default_nettype wire

// >>> inc/mpss_pkg.sv
// mpss_pkg: shared constants and types for the power state signalling block
// assumes a 100 MHz system clock; no software-visible registers
package mpss_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int PWRGOOD_SETTLE_NS = 1000;
	localparam int PWRGOOD_SETTLE_CYC = (PWRGOOD_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CARRIER_RESET_NS = 1000;
	localparam int CARRIER_RESET_CYC = (CARRIER_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SUSPEND_WARN_NS = 200;
	localparam int SUSPEND_WARN_CYC = (SUSPEND_WARN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 16;
	localparam int SYNC_STAGES = 2;
	localparam int NUM_IN = 10;
	// synchronised input indices
	localparam int IDX_POWER_BUTTON_N = 0;
	localparam int IDX_RSTBTN = 1;
	localparam int IDX_PWRGOOD = 2;
	localparam int IDX_WAKE_PCIE = 3;
	localparam int IDX_WAKE_GEN = 4;
	localparam int IDX_BATTERY_LOW_N = 5;
	localparam int IDX_ALERT = 6;
	localparam int IDX_OVERTEMP = 7;
	localparam int IDX_SLEEP = 8;
	localparam int IDX_LID = 9;
	localparam logic [NUM_IN-1:0] SYNC_RESET_VAL = 10'h3FB;

	typedef enum logic [2:0] {
		MPSS_OFF = 3'h0,
		MPSS_START = 3'h1,
		MPSS_RUN = 3'h3,
		MPSS_WARN = 3'h2,
		MPSS_S3 = 3'h6,
		MPSS_S4 = 3'h7
	} mpss_state_type;

	typedef enum logic [1:0] {
		MPSS_TGT_S3 = 2'h0,
		MPSS_TGT_S4 = 2'h1,
		MPSS_TGT_S5 = 2'h2
	} mpss_target_type;
endpackage

// >>> inc/mpss_sync_if.sv
// mpss_sync_if: carries synchronised pin levels from the synchroniser
// assumes both ends run on sys_clk
`timescale 1ns/1ps
`default_nettype none
interface mpss_sync_if;
	logic [mpss_pkg::NUM_IN-1:0] level;
	logic [mpss_pkg::NUM_IN-1:0] fall;
	modport source (output level, output fall);
	modport sink (input level, input fall);
endinterface
`default_nettype wire

// >>> verilog/mpss_sync.sv
// mpss_sync: two-flop synchronisers and falling-edge detection for pins
// assumes pins are asynchronous to sys_clk
`timescale 1ns/1ps
`default_nettype none
module mpss_sync
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [mpss_pkg::NUM_IN-1:0] pins,
	mpss_sync_if.source sync
);
	typedef struct packed {
		logic [mpss_pkg::NUM_IN-1:0] meta;
		logic [mpss_pkg::NUM_IN-1:0] stable;
		logic [mpss_pkg::NUM_IN-1:0] prev;
	} mpss_sync_state_type;

	mpss_sync_state_type state;
	mpss_sync_state_type next_state;

	always_comb
	begin
		next_state = state;
		next_state.meta = pins;
		// meta feeds only stable, never any edge logic
		next_state.stable = state.meta;
		next_state.prev = state.stable;
		if (!rst_n)
		begin
			next_state.meta = mpss_pkg::SYNC_RESET_VAL;
			next_state.stable = mpss_pkg::SYNC_RESET_VAL;
			next_state.prev = mpss_pkg::SYNC_RESET_VAL;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		state <= next_state;
	end

	assign sync.level = state.stable;
	assign sync.fall = state.prev & ~state.stable;
endmodule
`default_nettype wire

// >>> tb/mpss_chk.sv
// mpss_chk: port-level assertions for mpss_top
// assumes one sys_clk domain; bound to every mpss_top
`timescale 1ns/1ps
`default_nettype none
module mpss_chk
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic power_button_n,
	input wire logic reset_button_n,
	input wire logic power_good,
	input wire logic watchdog_timeout,
	input wire logic cpu_thermal_shutdown,
	input wire logic mgmt_bus_alert_n,
	input wire logic carrier_reset_n,
	input wire logic suspend_imminent_n,
	input wire logic suspend_to_ram_n,
	input wire logic watchdog_expired,
	input wire logic thermal_trip_n,
	input wire logic system_mgmt_interrupt_n,
	input wire logic power_button_event,
	input wire logic system_running
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// slack of a few cycles covers the synchroniser depth
	AST_PWR_EVT: assert property ($fell(power_button_n) |-> ##[2:6] power_button_event)
		else $error("power button event missing");
	AST_RST_BTN: assert property (!reset_button_n [*5] |-> !carrier_reset_n)
		else $error("reset button did not reset carrier");
	AST_NOT_RUN: assert property (!system_running [*2] |-> !carrier_reset_n)
		else $error("carrier reset released outside run");
	AST_PG_START: assert property ($rose(system_running) |-> $past(power_good, 3))
		else $error("startup without power good");
	AST_S3_WARN: assert property ($fell(suspend_to_ram_n) |-> !$past(suspend_imminent_n))
		else $error("suspend without warning");
	AST_WDT: assert property ($rose(watchdog_timeout) |-> ##[2:5] watchdog_expired)
		else $error("watchdog indicator not set");
	AST_THERM: assert property (cpu_thermal_shutdown [*4] |-> !thermal_trip_n)
		else $error("thermal trip not driven");
	AST_SMI: assert property (!mgmt_bus_alert_n [*4] |-> !system_mgmt_interrupt_n)
		else $error("alert did not raise interrupt");
endmodule
bind mpss_top mpss_chk i_mpss_chk (.sys_clk, .rst_n, .power_button_n, .reset_button_n,
	.power_good, .watchdog_timeout, .cpu_thermal_shutdown, .mgmt_bus_alert_n,
	.carrier_reset_n, .suspend_imminent_n, .suspend_to_ram_n, .watchdog_expired,
	.thermal_trip_n, .system_mgmt_interrupt_n, .power_button_event, .system_running);
`default_nettype wire

// >>> tb/mpss_carrier.sv
// mpss_carrier: carrier supply model that reports power good
// assumes supply_on comes from the bench, sys_clk free running
`timescale 1ns/1ps
`default_nettype none
module mpss_carrier
(
	input wire logic sys_clk,
	input wire logic supply_on,
	output logic power_good
);
	logic [2:0] ramp = 3'h0;
	// good only once the rail has settled, dropped at once
	assign power_good = supply_on && (ramp == 3'h7);
	always @(posedge sys_clk)
		ramp <= !supply_on ? 3'h0 : (ramp == 3'h7) ? ramp : ramp + 3'h1;
endmodule
`default_nettype wire

// >>> tb/mpss_top_tb.sv
// mpss_top_tb: scenario bench for the power state signalling block
// assumes the checker is bound and the carrier model drives power good
`timescale 1ns/1ps
`default_nettype none
module mpss_top_tb;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic supply_on = 1'b0;
	logic [1:0] tgt = 2'h0;
	logic [14:0] drv = 15'h01FF;
	localparam logic [14:0] RST_OBS = 15'h00CE;
	int n_errors = 0;
	int n_checks = 0;
	wire logic power_good;
	wire logic carrier_reset_n, suspend_imminent_n, suspend_to_ram_n, suspend_to_disk_n;
	wire logic soft_off_n, watchdog_expired, thermal_trip_n, system_mgmt_interrupt_n;
	wire logic over_temp, power_button_event, sleep_button_event, lid_event;
	wire logic wake_event, battery_low, system_running;
	wire logic [14:0] obs = {system_running, battery_low, wake_event, lid_event,
		sleep_button_event, power_button_event, over_temp, system_mgmt_interrupt_n,
		thermal_trip_n, watchdog_expired, soft_off_n, suspend_to_disk_n, suspend_to_ram_n,
		suspend_imminent_n, carrier_reset_n};
	always #5 sys_clk = ~sys_clk;
	mpss_carrier i_mpss_carrier (.sys_clk, .supply_on, .power_good);
	mpss_top #(.PWRGOOD_SETTLE(4), .CARRIER_RESET(4), .SUSPEND_WARN(3)) i_mpss_top (
		.sys_clk, .rst_n, .power_button_n(drv[0]), .reset_button_n(drv[1]), .power_good,
		.main_supply_low(drv[9]), .pcie_wake_n(drv[2]), .general_wake_n(drv[3]),
		.battery_low_n(drv[4]), .mgmt_bus_alert_n(drv[5]), .over_temp_in_n(drv[6]),
		.sleep_button_n(drv[7]), .lid_switch_n(drv[8]), .watchdog_timeout(drv[10]),
		.watchdog_clear(drv[11]), .sw_reset_req(drv[12]), .sleep_enter_req(drv[13]),
		.sleep_target(tgt), .cpu_thermal_shutdown(drv[14]), .carrier_reset_n,
		.suspend_imminent_n, .suspend_to_ram_n, .suspend_to_disk_n, .soft_off_n,
		.watchdog_expired, .thermal_trip_n, .system_mgmt_interrupt_n, .over_temp,
		.power_button_event, .sleep_button_event, .lid_event, .wake_event, .battery_low,
		.system_running);
	task test_done();
		if (n_errors == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task check(input logic got, input logic exp);
		n_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// polled every cycle so one-cycle pulses are not missed
	task wait_bit(input int i, input logic v, input int lim);
		int k;
		k = 0;
		while (obs[i] !== v && k < lim)
		begin
			@(posedge sys_clk);
			#1;
			k++;
		end
		check(obs[i], v);
	endtask
	task pulse(input int i, input int n);
		@(posedge sys_clk) drv[i] <= ~drv[i];
		repeat (n) @(posedge sys_clk);
		drv[i] <= ~drv[i];
		#1;
	endtask
	task t_reset();
		for (int k = 0; k < 15; k++)
			check(obs[k], RST_OBS[k]);
	endtask
	task t_power_on();
		pulse(0, 3);
		wait_bit(9, 1'b1, 10);
		repeat (30) @(posedge sys_clk);
		check(system_running, 1'b0);
		supply_on <= 1'b1;
		wait_bit(14, 1'b1, 40);
		wait_bit(0, 1'b1, 40);
		check(soft_off_n, 1'b1);
	endtask
	task t_cause(input int i);
		pulse(i, 6);
		wait_bit(0, 1'b0, 10);
		wait_bit(14, 1'b1, 40);
		wait_bit(0, 1'b1, 40);
	endtask
	task t_power_drop();
		@(posedge sys_clk) supply_on <= 1'b0;
		wait_bit(0, 1'b0, 10);
		check(system_running, 1'b1);
		@(posedge sys_clk) supply_on <= 1'b1;
		wait_bit(0, 1'b1, 40);
	endtask
	task t_watchdog();
		pulse(10, 1);
		wait_bit(5, 1'b1, 8);
		wait_bit(0, 1'b0, 8);
		repeat (20) @(posedge sys_clk);
		check(watchdog_expired, 1'b1);
		pulse(11, 1);
		wait_bit(5, 1'b0, 8);
		wait_bit(0, 1'b1, 40);
	endtask
	task t_sleep(input logic [1:0] t, input int s, input int w);
		@(posedge sys_clk) tgt <= t;
		pulse(13, 1);
		wait_bit(1, 1'b0, 8);
		wait_bit(s, 1'b0, 12);
		// wake pulse is over before the pin returns high
		fork
			pulse(w, 4);
			wait_bit(12, 1'b1, 10);
		join
		wait_bit(14, 1'b1, 40);
	endtask
	task t_sleep_button();
		pulse(7, 3);
		wait_bit(10, 1'b1, 10);
		wait_bit(2, 1'b0, 15);
		fork
			pulse(5, 4);
			wait_bit(12, 1'b1, 10);
		join
		wait_bit(14, 1'b1, 40);
	endtask
	task t_off(input int i, input int n, input logic [1:0] t);
		@(posedge sys_clk) tgt <= t;
		pulse(i, n);
		check(battery_low, i == 4);
		check(thermal_trip_n, i != 14);
		wait_bit(4, 1'b0, 15);
		pulse(0, 3);
		wait_bit(14, 1'b1, 40);
	endtask
	task t_levels();
		@(posedge sys_clk) drv[6] <= 1'b0;
		drv[8] <= 1'b0;
		wait_bit(11, 1'b1, 10);
		wait_bit(8, 1'b1, 10);
		@(posedge sys_clk) drv[6] <= 1'b1;
		drv[8] <= 1'b1;
		wait_bit(8, 1'b0, 10);
	endtask
	initial
	begin
		repeat (5) @(posedge sys_clk);
		#1;
		t_reset();
		@(posedge sys_clk) rst_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		#1;
		t_reset();
		t_power_on();
		t_cause(1);
		t_cause(9);
		t_cause(12);
		t_power_drop();
		t_watchdog();
		t_sleep(2'h0, 2, 2);
		t_sleep(2'h1, 3, 3);
		t_sleep_button();
		t_off(13, 1, 2'h2);
		t_off(4, 12, 2'h0);
		t_off(14, 12, 2'h0);
		t_levels();
		test_done();
	end
	initial
	begin
		repeat (5000) @(posedge sys_clk);
		n_errors++;
		test_done();
	end
endmodule
`default_nettype wire
